/* bench/tec_pin_src.sv */
// Timer pin source: toggles the pin n times, one change every 8 clocks
module tec_pin_src (
  input wire logic clk,
  input wire logic go,
  input wire logic [3:0] n,
  output logic pin,
  output logic busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] left = 4'h0;
  logic [2:0] gap = 3'h0;
  initial pin = 1'b1;
  assign busy = go | (left != 4'h0);
  always @(posedge clk)
    if (go)
      left <= n;
    else if (left != 4'h0)
    begin
      gap <= gap + 3'h1;
      if (gap == 3'h7)
      begin
        pin <= ~pin;
        left <= left - 4'h1;
      end
    end
endmodule // tec_pin_src

/* bench/tec_timer_properties.sv */
// Port-level properties of the timer block
module tec_timer_props (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire sleep_mode,
  input wire timer_irq,
  input wire wake_up
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire rd = pready & ~pwrite;
  wire hit = (paddr == 12'h000) | (paddr == 12'h004) | (paddr == 12'h008);
  property p_rdy; psel && !penable |=> pready && penable; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("ready held");
  property p_err; pslverr |-> pready && !hit; endproperty
  a_err: assert property (p_err) else $error("bad error");
  property p_map; pready && hit |-> !pslverr; endproperty
  a_map: assert property (p_map) else $error("mapped error");
  property p_b5; rd && paddr == 12'h004 |-> prdata[31:8] == 24'h00_0000 && !prdata[5]; endproperty
  a_b5: assert property (p_b5) else $error("ctrl bits");
  property p_idle; !rd |-> prdata == 32'h0000_0000; endproperty
  a_idle: assert property (p_idle) else $error("read data");
  property p_wake; wake_up |-> sleep_mode || $past(sleep_mode); endproperty
  a_wake: assert property (p_wake) else $error("wake");
  property p_rst; $rose(presetn) |-> !timer_irq && !wake_up && !pready; endproperty
  a_rst: assert property (p_rst) else $error("reset");
  c_irq: cover property (timer_irq);
  c_wake: cover property (wake_up);
  c_err: cover property (pslverr);
endmodule // tec_timer_props
bind tec_timer tec_timer_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .sleep_mode(sleep_mode), .timer_irq(timer_irq), .wake_up(wake_up));

/* bench/tec_timer_tb.sv */
// Self-checking bench for the timer block
module tec_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, sleep_mode, go, pin, busy, err, woke, irqd;
  logic slow_tick;
  logic pready, pslverr, timer_irq, wake_up;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, v;
  logic [3:0] n, div;
  int miscompares, comparisons, c, k;
  tec_timer uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_pin(pin), .low_speed_osc_tick(slow_tick),
    .sleep_mode(sleep_mode),
    .timer_irq(timer_irq), .wake_up(wake_up));
  tec_pin_src src (.clk(pclk), .go(go), .n(n), .pin(pin), .busy(busy));
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    if (wake_up === 1'b1)
      woke <= 1'b1;
    if (timer_irq === 1'b1)
      irqd <= 1'b1;
  end
  // Slow oscillator stand-in: one tick every 16 clocks
  always @(posedge pclk)
  begin
    div <= div + 4'h1;
    slow_tick <= (div == 4'hF);
  end
  task tally_and_finish;
    if (miscompares == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    comparisons++;
    if ($isunknown(got) || got < lo || got > hi)
    begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, got, lo);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20 && pready !== 1'b1; i++)
      @(posedge pclk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 20)
    begin
      miscompares++;
      tally_and_finish;
    end
  endtask
  task wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h00_0000, d});
  endtask
  task rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask
  task eq(input logic [7:0] e);
    chk(q, {24'h00_0000, e}, {24'h00_0000, e});
  endtask
  task pulse(input logic [3:0] t);
    go <= 1'b1;
    n <= t;
    @(posedge pclk);
    go <= 1'b0;
    for (c = 0; c < 200 && busy !== 1'b0; c++)
      @(posedge pclk);
    if (c == 200)
    begin
      miscompares++;
      tally_and_finish;
    end
    // Pin sync plus edge compare takes three clocks
    repeat (4) @(posedge pclk);
  endtask
  task t_regs;
    rd(12'h004);
    eq(8'h08);
    wr(12'h004, 8'hFF);
    rd(12'h004);
    eq(8'hDF);
    wr(12'h004, 8'h00);
    rd(12'h00C);
    chk(32'(err), 1, 1);
    wr(12'h000, 8'h5A);
    rd(12'h000);
    eq(8'h5A);
    wr(12'h004, 8'h10);
    repeat (40) @(posedge pclk);
    rd(12'h000);
    eq(8'h5A);
  endtask
  task t_timer;
    wr(12'h008, 8'h04);
    for (k = 0; k < 8; k++)
    begin
      wr(12'h004, 8'h80 | 8'(k));
      wr(12'h000, 8'hF0);
      wr(12'h004, 8'h90 | 8'(k));
      for (c = 0; c < 3000 && timer_irq !== 1'b1; c++)
        @(posedge pclk);
      chk(c, 15 << k, (16 << k) + 6);
      if (c == 3000)
        tally_and_finish;
    end
    wr(12'h000, 8'h33);
    rd(12'h000);
    eq(8'hF0);
    for (c = 0; c < 3000 && timer_irq !== 1'b1; c++)
      @(posedge pclk);
    if (c == 3000)
    begin
      miscompares++;
      tally_and_finish;
    end
    rd(12'h000);
    eq(8'h33);
  endtask
  task t_src;
    for (k = 1; k < 3; k++)
    begin
      wr(12'h008, 8'h04 | 8'(k));
      wr(12'h004, 8'h80);
      wr(12'h000, 8'hF0);
      wr(12'h004, 8'h90);
      for (c = 0; c < 3000 && timer_irq !== 1'b1; c++)
        @(posedge pclk);
      chk(c, 15 << (2 * k), (16 << (2 * k)) + 6);
      if (c == 3000)
        tally_and_finish;
    end
  endtask
  task t_reset;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h004);
    eq(8'h08);
    rd(12'h000);
    eq(8'h00);
  endtask
  task t_event;
    sleep_mode <= 1'b1;
    for (k = 1; k >= 0; k--)
    begin
      wr(12'h008, 8'(k << 2));
      wr(12'h004, 8'h47 | 8'(k << 3));
      wr(12'h000, 8'hFD);
      wr(12'h004, 8'h57 | 8'(k << 3));
      woke <= 1'b0;
      irqd <= 1'b0;
      pulse(4'h7);
      rd(12'h000);
      eq(8'hFE);
      chk(32'(woke), 1, 1);
      chk(32'(irqd), k, k);
    end
    sleep_mode <= 1'b0;
  endtask
  task t_pwc;
    wr(12'h004, 8'hC0);
    wr(12'h000, 8'h00);
    wr(12'h004, 8'hD0);
    repeat (20) @(posedge pclk);
    rd(12'h000);
    eq(8'h00);
    pulse(4'h2);
    rd(12'h000);
    v = q;
    chk(q, 7, 9);
    rd(12'h004);
    eq(8'hC0);
    pulse(4'h2);
    rd(12'h000);
    chk(q, v, v);
  endtask
  initial
  begin
    presetn = 1'b0;
    {psel, penable, pwrite, sleep_mode, go, woke, irqd, slow_tick} = 8'h00;
    div = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    n = 4'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_timer;
    t_src;
    t_event;
    t_pwc;
    t_reset;
    tally_and_finish;
  end
endmodule // tec_timer_tb

/* rtl/tec_consts.vh */
// Constants for the 8-bit timer/event counter
`ifndef TEC_CONSTS_VH
`define TEC_CONSTS_VH
// Register byte addresses on APB
`define TEC_ADDR_COUNT 12'h000
`define TEC_ADDR_CTRL 12'h004
`define TEC_ADDR_SYSCFG 12'h008
// Control field positions
`define TEC_MODE_HI 7
`define TEC_MODE_LO 6
`define TEC_EN_BIT 4
`define TEC_EDGE_BIT 3
`define TEC_PSC_HI 2
`define TEC_PSC_LO 0
// System config field positions
`define TEC_CLKSEL_HI 1
`define TEC_CLKSEL_LO 0
`define TEC_IRQEN_BIT 2
// Reset values
`define TEC_CTRL_RST 8'h08
`define TEC_SYSCFG_RST 8'h00
`define TEC_COUNT_RST 8'h00
// Mode codes
`define TEC_MODE_NONE 2'b00
`define TEC_MODE_EVENT 2'b01
`define TEC_MODE_TIMER 2'b10
`define TEC_MODE_PWC 2'b11
// Clock source codes
`define TEC_SRC_SYS 2'b00
`define TEC_SRC_SYS4 2'b01
`define TEC_SRC_SLOW 2'b10
// Timing counts
`define TEC_SYS4_DIV 2'd3
`define TEC_COUNT_FULL 8'hff
`endif

/* rtl/tec_timer.v */
// 8-bit timer/event counter with APB register access
//
// The register addresses and the APB slave port were left to the implementer.
`include "tec_consts.vh"

module tec_timer
(
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire timer_pin,
  input wire low_speed_osc_tick,
  input wire sleep_mode,
  output reg timer_irq,
  output reg wake_up
);

  reg [7:0] count_value_register;
  reg [7:0] preload;
  reg [1:0] operating_mode_select;
  reg count_enable;
  reg active_edge_select;
  reg [2:0] prescale_ratio_select;
  reg [1:0] timer_clock_source_select;
  reg timer_interrupt_enable;
  reg pin_meta;
  reg pin_sync;
  reg pin_last;
  reg [1:0] sys4_cnt;
  reg [6:0] psc_cnt;
  reg psc_last;
  reg pwc_active;
  reg [7:0] next_count;
  reg next_ovf;
  reg src_tick;
  reg psc_out;
  reg tick;
  reg int_tick;
  wire acc;
  wire wr;
  wire rd;
  wire addr_ok;
  wire hold;
  wire rise;
  wire fall;
  wire pwc_start;
  wire pwc_stop;
  wire ctrl_wr;
  wire preload_wr;
  wire syscfg_wr;

  assign acc = psel & penable & pready;
  assign wr = acc & pwrite;
  assign rd = acc & ~pwrite;
  assign addr_ok = (paddr == `TEC_ADDR_COUNT) | (paddr == `TEC_ADDR_CTRL) |
                   (paddr == `TEC_ADDR_SYSCFG);
  assign ctrl_wr = wr & (paddr == `TEC_ADDR_CTRL);
  assign preload_wr = wr & (paddr == `TEC_ADDR_COUNT);
  assign syscfg_wr = wr & (paddr == `TEC_ADDR_SYSCFG);
  // clock inhibit
  // Ticks lost here are a counting error the user must allow for
  // Count read and preload write share one offset, so one compare covers both
  assign hold = psel & (paddr == `TEC_ADDR_COUNT);

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      // Pulled-up idle level, so no false edge follows reset
      pin_meta <= 1'b1;
      pin_sync <= 1'b1;
      pin_last <= 1'b1;
    end
    else
    begin
      pin_meta <= timer_pin;
      pin_sync <= pin_meta;
      pin_last <= pin_sync;
    end
  end

  assign rise = pin_sync & ~pin_last;
  assign fall = ~pin_sync & pin_last;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sys4_cnt <= 2'd0;
    else if (sys4_cnt == `TEC_SYS4_DIV)
      sys4_cnt <= 2'd0;
    else
      sys4_cnt <= sys4_cnt + 2'd1;
  end

  always @*
  begin
    if (timer_clock_source_select == `TEC_SRC_SYS)
      src_tick = 1'b1;
    else if (timer_clock_source_select == `TEC_SRC_SYS4)
      src_tick = (sys4_cnt == `TEC_SYS4_DIV);
    else if (timer_clock_source_select == `TEC_SRC_SLOW)
      src_tick = low_speed_osc_tick;
    else
      src_tick = 1'b0;
  end

  // prescaler counter
  // Free-running, so the first prescaled tick may come up to one period early
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      psc_cnt <= 7'd0;
    else if (src_tick)
      psc_cnt <= psc_cnt + 7'd1;
  end

  // ratio select
  // Code 0 uses the source tick itself as a falling edge of the clock
  always @*
  begin
    psc_out = 1'b0;
    if (prescale_ratio_select != 3'd0)
      psc_out = psc_cnt[prescale_ratio_select - 3'd1];
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      psc_last <= 1'b0;
    else
      psc_last <= psc_out;
  end

  // prescaled internal tick
  // Shared by timer and pulse capture, so both use one time base
  always @*
  begin
    if (prescale_ratio_select == 3'd0)
      int_tick = src_tick;
    else
      int_tick = psc_last & ~psc_out;
  end

  assign pwc_start = active_edge_select ? rise : fall;
  assign pwc_stop = active_edge_select ? fall : rise;

  always @*
  begin
    tick = 1'b0;
    case (operating_mode_select)
      `TEC_MODE_EVENT:
        tick = active_edge_select ? fall : rise;
      `TEC_MODE_TIMER:
        tick = int_tick;
      `TEC_MODE_PWC:
        tick = pwc_active & int_tick;
      default:
        tick = 1'b0;
    endcase
  end

  always @*
  begin
    next_count = count_value_register;
    next_ovf = 1'b0;
    if (count_enable & tick & ~hold)
    begin
      // A preload of FF turns every tick into an overflow
      // overflow reload
      if (count_value_register == `TEC_COUNT_FULL)
      begin
        next_count = preload;
        next_ovf = 1'b1;
      end
      else
        next_count = count_value_register + 8'd1;
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count_value_register <= `TEC_COUNT_RST;
      preload <= `TEC_COUNT_RST;
    end
    else if (preload_wr)
    begin
      preload <= pwdata[7:0];
      if (!count_enable)
        count_value_register <= pwdata[7:0];
    end
    else
      count_value_register <= next_count;
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      timer_clock_source_select <= `TEC_SRC_SYS;
      timer_interrupt_enable <= 1'b0;
    end
    else if (syscfg_wr)
    begin
      timer_clock_source_select <= pwdata[`TEC_CLKSEL_HI:`TEC_CLKSEL_LO];
      timer_interrupt_enable <= pwdata[`TEC_IRQEN_BIT];
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      operating_mode_select <= `TEC_MODE_NONE;
      count_enable <= 1'b0;
      active_edge_select <= 1'b1;
      prescale_ratio_select <= 3'd0;
      pwc_active <= 1'b0;
    end
    else
    begin
      if (ctrl_wr)
      begin
        operating_mode_select <= pwdata[`TEC_MODE_HI:`TEC_MODE_LO];
        count_enable <= pwdata[`TEC_EN_BIT];
        active_edge_select <= pwdata[`TEC_EDGE_BIT];
        prescale_ratio_select <= pwdata[`TEC_PSC_HI:`TEC_PSC_LO];
        pwc_active <= 1'b0;
      end
      else if ((operating_mode_select == `TEC_MODE_PWC) & count_enable)
      begin
        if (!pwc_active & pwc_start)
          pwc_active <= 1'b1;
        else if (pwc_active & pwc_stop)
        begin
          pwc_active <= 1'b0;
          count_enable <= 1'b0;
        end
      end
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      timer_irq <= 1'b0;
      wake_up <= 1'b0;
    end
    else
    begin
      timer_irq <= next_ovf & timer_interrupt_enable;
      // Wake ignores the interrupt enable, so sleep exit never depends on it
      // wake from sleep
      wake_up <= next_ovf & sleep_mode;
    end
  end

  // Zero-wait-state slave; setup phase raises pready for the access
  // Read data is latched in setup, while the count is held off
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~addr_ok;
      prdata <= 32'h0000_0000;
      if (psel & ~penable & ~pwrite)
      begin
        if (paddr == `TEC_ADDR_COUNT)
          prdata <= {24'h00_0000, count_value_register};
        else if (paddr == `TEC_ADDR_CTRL)
          prdata <= {24'h00_0000, operating_mode_select, 1'b0, count_enable,
                     active_edge_select, prescale_ratio_select};
        else if (paddr == `TEC_ADDR_SYSCFG)
          prdata <= {29'h0000_0000, timer_interrupt_enable, timer_clock_source_select};
      end
    end
  end

endmodule // tec_timer
